// [rsw_pkg.sv]
package rsw_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int GAP_HALF_CHARS = 7;              // 3.5 character times, in half characters
   localparam int DEF_CHAR_NS = 1000000;           // Plain default, one character time
   // ----------------------------------------
   // Frame layout and function codes
   // ----------------------------------------
   localparam logic [7:0] FN_READ = 8'h03;
   localparam logic [7:0] FN_DIAG = 8'h08;
   localparam logic [7:0] FN_WMULTI = 8'h10;
   localparam logic [7:0] FN_EXC_BIT = 8'h80;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [7:0] EXC_VALUE = 8'h03;
   localparam logic [7:0] EXC_REFUSED = 8'h04;
   localparam logic [15:0] MAX_WORDS = 16'h0010;
   localparam int RX_DEPTH = 48;
   localparam logic [5:0] DIAG_LEN = 6'h08;
   localparam logic [5:0] WR_HDR_LEN = 6'h09;
   localparam logic [5:0] WECHO_LEN = 6'h06;
   localparam logic [5:0] RD_HDR_LEN = 6'h03;
   localparam logic [6:0] FACTORY_RESERVED_GROUP = 7'h63; // Group 99 as its hex form
   // ----------------------------------------
   // Locally held parameters
   // ----------------------------------------
   localparam logic [15:0] REG_PLC_RUN_PATTERN = 16'h0A00;
   localparam logic [15:0] REG_PLC_RETENTION_SELECT = 16'h0A01;
   localparam logic [15:0] RST_PLC_RUN_PATTERN = 16'h0000;
   localparam logic [15:0] RST_PLC_RETENTION_SELECT = 16'h0000;
   localparam logic [15:0] MAX_PLC_RUN_PATTERN = 16'h0002;
   localparam logic [15:0] MAX_PLC_RETENTION_SELECT = 16'h0001;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CHECK = 3'b001,
      ST_COMMIT = 3'b010,
      ST_SEND = 3'b011
   } rsw_state_t;

   typedef enum logic [1:0] {
      MD_COPY = 2'b00,
      MD_READ = 2'b01,
      MD_EXC = 2'b10
   } rsw_mode_t;

   // Parameter write strobe towards the storage logic
   typedef struct packed {
      logic valid;
      logic ram_only;
      logic [15:0] addr;
      logic [15:0] data;
   } rsw_par_wr_t;
endpackage

// [rsw_slave.sv]
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Frames are delimited by at least 3.5 character times of line idle.
// [RULE2] Diagnosis sub-function zero returns the query byte for byte.
// [RULE3] Write-multiple stores consecutive words from the start address, at most sixteen.
// [RULE4] Request: address, command, start, quantity, byte count, data high first, check.
// [RULE5] Write-multiple answer echoes address, command, start, quantity, then fresh check.
// [RULE6] Register address is group number high byte, index low byte.
// [RULE7] Factory reserved group is refused for reads and writes.
// [RULE8] Running-locked writes refused while running; never-writable parameters always refused.
// [RULE9] Top address bit set means write only the RAM copy.
// [RULE10] Reads at a RAM-only alias address are invalid.
// [RULE11] Run pattern accepts 0, 1 or 2, defaults to 0.
// [RULE12] Retention select accepts 0 or 1, defaults to 0.
// [RULE13] Frame check goes low byte first; addresses and data go high first.
// [RULE14] Only frames carrying our own station address are acted upon.
// [RULE15] Frames with a bad frame check are dropped without answer.
module rsw_slave #(
   parameter int P_CHAR_NS = rsw_pkg::DEF_CHAR_NS
) (
   input wire logic i_clk,                          // 50 MHz system clock
   input wire logic i_rst_b,                        // Async reset, active low
   input wire logic [7:0] i_station_addr,           // Own station address
   input wire logic i_rx_valid,                     // Received byte strobe
   input wire logic [7:0] i_rx_data,                // Received byte
   input wire logic i_tx_ready,                     // Transmitter takes byte
   output logic o_tx_valid,                         // Byte to send is valid
   output logic [7:0] o_tx_data,                    // Byte to send
   input wire logic i_running,                      // Drive is running
   input wire logic i_lock_run,                     // Probed address locked while running
   input wire logic i_lock_never,                   // Probed address never writable
   output logic [15:0] o_probe_addr,                // Address under check
   output rsw_pkg::rsw_par_wr_t o_par_wr,           // Parameter write strobe
   output logic [15:0] o_plc_run_pattern,           // Run pattern value
   output logic [15:0] o_plc_retention_select       // Retention select value
);
   import rsw_pkg::*;

   localparam int GAP_CYC = (P_CHAR_NS * GAP_HALF_CHARS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int k = 0; k < 8; k++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta_r, rst_b_r;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_meta_r <= 1'b0;
         rst_b_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_b_r <= rst_meta_r;
      end
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [7:0] rx_mem [RX_DEPTH];
   logic [5:0] rx_cnt_r, rx_cnt_nxt, tx_len_r, tx_len_nxt, tx_idx_r, tx_idx_nxt;
   logic ovf_r, ovf_nxt;
   logic [15:0] rcrc_r, rcrc_nxt, tcrc_r, tcrc_nxt;
   logic [31:0] gap_r, gap_nxt;
   rsw_state_t st_r, st_nxt;
   rsw_mode_t md_r, md_nxt;
   logic [7:0] exc_r, exc_nxt;
   logic [4:0] idx_r, idx_nxt;
   logic [15:0] cur_r, cur_nxt, pat_r, pat_nxt, ret_r, ret_nxt;
   rsw_par_wr_t pw_r, pw_nxt;
   logic out_v_r, out_v_nxt, sk_v_r, sk_v_nxt;
   logic [7:0] out_d_r, out_d_nxt, sk_d_r, sk_d_nxt;

   // Decoded request fields
   logic [7:0] f_fn, f_bc;
   logic [15:0] f_start, f_qty, f_word;
   logic frame_end, frame_ok, refuse, push;
   logic [7:0] push_d;
   logic [5:0] rd_off;
   assign f_fn = rx_mem[1];
   assign f_start = {rx_mem[2], rx_mem[3]};                      // see [RULE13]
   assign f_qty = {rx_mem[4], rx_mem[5]};
   assign f_bc = rx_mem[6];
   assign f_word = {rx_mem[6'd7 + {idx_r, 1'b0}], rx_mem[6'd8 + {idx_r, 1'b0}]}; // see [RULE4]
   assign frame_end = (st_r == ST_IDLE) && (gap_r == 32'(GAP_CYC)) && (rx_cnt_r != 6'h00); // see [RULE1]
   assign frame_ok = !ovf_r && (rcrc_r == 16'h0000) && (rx_cnt_r >= 6'h04)
                     && (rx_mem[0] == i_station_addr);            // see [RULE15] see [RULE14]
   assign rd_off = tx_idx_r - RD_HDR_LEN;

   // Receive store; memory holds no reset value
   always_ff @(posedge i_clk) begin
      if (st_r == ST_IDLE && i_rx_valid && rx_cnt_r < 6'(RX_DEPTH)) begin
         rx_mem[rx_cnt_r] <= i_rx_data;
      end
   end

   // Refusal of the word under commit
   always_comb begin
      refuse = (cur_r[14:8] == FACTORY_RESERVED_GROUP)                   // see [RULE7]
               || i_lock_never || (i_lock_run && i_running);             // see [RULE8]
      if (cur_r[14:0] == REG_PLC_RUN_PATTERN[14:0] && f_word > MAX_PLC_RUN_PATTERN) begin
         refuse = 1'b1;                                                  // see [RULE11]
      end else if (cur_r[14:0] == REG_PLC_RETENTION_SELECT[14:0] && f_word > MAX_PLC_RETENTION_SELECT) begin
         refuse = 1'b1;                                                  // see [RULE12]
      end
   end

   // Byte source for the answer, check appended low byte first
   always_comb begin
      push = (st_r == ST_SEND) && !sk_v_r;
      if (tx_idx_r == tx_len_r) begin
         push_d = tcrc_r[7:0];                                           // see [RULE13]
      end else if (tx_idx_r == tx_len_r + 6'h01) begin
         push_d = tcrc_r[15:8];
      end else if (md_r == MD_COPY) begin
         push_d = rx_mem[tx_idx_r];                                      // see [RULE2] see [RULE5]
      end else if (tx_idx_r == 6'h00) begin
         push_d = rx_mem[0];
      end else if (tx_idx_r == 6'h01) begin
         push_d = (md_r == MD_EXC) ? (f_fn | FN_EXC_BIT) : f_fn;
      end else if (tx_idx_r == 6'h02) begin
         push_d = (md_r == MD_EXC) ? exc_r : {f_qty[6:0], 1'b0};
      end else begin
         push_d = (f_start[0] ^ rd_off[1]) ? (rd_off[0] ? ret_r[7:0] : ret_r[15:8])
                                          : (rd_off[0] ? pat_r[7:0] : pat_r[15:8]);
      end
   end

   // Command sequencing
   always_comb begin
      st_nxt = st_r;
      md_nxt = md_r;
      exc_nxt = exc_r;
      idx_nxt = idx_r;
      cur_nxt = cur_r;
      pat_nxt = pat_r;
      ret_nxt = ret_r;
      tx_len_nxt = tx_len_r;
      tx_idx_nxt = tx_idx_r;
      tcrc_nxt = tcrc_r;
      pw_nxt = pw_r;
      pw_nxt.valid = 1'b0;
      rx_cnt_nxt = rx_cnt_r;
      ovf_nxt = ovf_r;
      rcrc_nxt = rcrc_r;
      // Idle counter restarts on every byte, even while busy
      gap_nxt = i_rx_valid ? 32'h0 : ((gap_r == 32'(GAP_CYC)) ? gap_r : gap_r + 32'h1);
      if (st_r == ST_IDLE && i_rx_valid) begin
         rcrc_nxt = crc_step(rcrc_r, i_rx_data);
         if (rx_cnt_r < 6'(RX_DEPTH)) begin
            rx_cnt_nxt = rx_cnt_r + 6'h01;
         end else begin
            ovf_nxt = 1'b1;
         end
      end
      case (st_r)
         ST_IDLE: begin
            if (frame_end) begin
               rx_cnt_nxt = 6'h00;
               ovf_nxt = 1'b0;
               rcrc_nxt = CRC_INIT;
               tx_idx_nxt = 6'h00;
               tcrc_nxt = CRC_INIT;
               md_nxt = MD_EXC;
               tx_len_nxt = RD_HDR_LEN;
               if (frame_ok) begin
                  st_nxt = ST_SEND;
                  if (f_fn == FN_DIAG && rx_cnt_r == DIAG_LEN && f_start == 16'h0000) begin
                     md_nxt = MD_COPY;                                   // see [RULE2]
                     tx_len_nxt = DIAG_LEN - 6'h02;
                  end else if (f_fn == FN_WMULTI) begin
                     exc_nxt = EXC_VALUE;
                     if (f_qty != 16'h0000 && f_qty <= MAX_WORDS && f_bc == {f_qty[6:0], 1'b0}
                         && rx_cnt_r == WR_HDR_LEN + {f_qty[4:0], 1'b0}) begin // see [RULE3] see [RULE4]
                        st_nxt = ST_CHECK;
                        idx_nxt = 5'h00;
                     end
                  end else if (f_fn == FN_READ) begin
                     exc_nxt = EXC_ADDR;
                     if (f_start[15] || f_start[14:8] == FACTORY_RESERVED_GROUP) begin
                        exc_nxt = EXC_ADDR;                              // see [RULE10] see [RULE7]
                     end else if (rx_cnt_r == DIAG_LEN && f_qty != 16'h0000 && f_qty <= 16'h0002
                                  && f_start >= REG_PLC_RUN_PATTERN
                                  && f_start + f_qty <= REG_PLC_RETENTION_SELECT + 16'h0001) begin
                        md_nxt = MD_READ;
                        tx_len_nxt = RD_HDR_LEN + {f_qty[4:0], 1'b0};
                     end
                  end else begin
                     exc_nxt = EXC_FUNC;
                  end
               end
            end
         end
         ST_CHECK: begin
            cur_nxt = f_start + {11'h000, idx_r};                        // see [RULE3] see [RULE6]
            st_nxt = ST_COMMIT;
         end
         ST_COMMIT: begin
            if (refuse) begin
               exc_nxt = EXC_REFUSED;
               st_nxt = ST_SEND;
            end else begin
               pw_nxt.valid = 1'b1;
               pw_nxt.ram_only = cur_r[15];                              // see [RULE9]
               pw_nxt.addr = {1'b0, cur_r[14:0]};
               pw_nxt.data = f_word;
               if (cur_r[14:0] == REG_PLC_RUN_PATTERN[14:0]) begin
                  pat_nxt = f_word;                                      // see [RULE11]
               end else if (cur_r[14:0] == REG_PLC_RETENTION_SELECT[14:0]) begin
                  ret_nxt = f_word;                                      // see [RULE12]
               end
               if ({11'h000, idx_r} == f_qty - 16'h0001) begin
                  md_nxt = MD_COPY;                                      // see [RULE5]
                  tx_len_nxt = WECHO_LEN;
                  st_nxt = ST_SEND;
               end else begin
                  idx_nxt = idx_r + 5'h01;
                  st_nxt = ST_CHECK;
               end
            end
         end
         ST_SEND: begin
            if (push) begin
               tx_idx_nxt = tx_idx_r + 6'h01;
               // Check bytes must not fold into the check
               if (tx_idx_r < tx_len_r) begin
                  tcrc_nxt = crc_step(tcrc_r, push_d);
               end
               if (tx_idx_r == tx_len_r + 6'h01) begin
                  st_nxt = ST_IDLE;
               end
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   // Two-entry output buffer; a stalled transmitter holds the sender, no byte lost
   always_comb begin
      out_v_nxt = out_v_r;
      out_d_nxt = out_d_r;
      sk_v_nxt = sk_v_r;
      sk_d_nxt = sk_d_r;
      if (!out_v_r || i_tx_ready) begin
         if (sk_v_r) begin
            out_v_nxt = 1'b1;
            out_d_nxt = sk_d_r;
            sk_v_nxt = 1'b0;
         end else begin
            out_v_nxt = push;
            out_d_nxt = push_d;
         end
      end else if (push) begin
         sk_v_nxt = 1'b1;
         sk_d_nxt = push_d;
      end
   end

   // Register all state except the receive store
   always_ff @(posedge i_clk or negedge rst_b_r) begin
      if (!rst_b_r) begin
         st_r <= ST_IDLE;
         md_r <= MD_COPY;
         exc_r <= 8'h00;
         idx_r <= 5'h00;
         cur_r <= 16'h0000;
         pat_r <= RST_PLC_RUN_PATTERN;
         ret_r <= RST_PLC_RETENTION_SELECT;
         tx_len_r <= 6'h00;
         tx_idx_r <= 6'h00;
         tcrc_r <= CRC_INIT;
         pw_r <= '0;
         rx_cnt_r <= 6'h00;
         ovf_r <= 1'b0;
         rcrc_r <= CRC_INIT;
         gap_r <= 32'h0;
         out_v_r <= 1'b0;
         out_d_r <= 8'h00;
         sk_v_r <= 1'b0;
         sk_d_r <= 8'h00;
      end else begin
         st_r <= st_nxt;
         md_r <= md_nxt;
         exc_r <= exc_nxt;
         idx_r <= idx_nxt;
         cur_r <= cur_nxt;
         pat_r <= pat_nxt;
         ret_r <= ret_nxt;
         tx_len_r <= tx_len_nxt;
         tx_idx_r <= tx_idx_nxt;
         tcrc_r <= tcrc_nxt;
         pw_r <= pw_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         ovf_r <= ovf_nxt;
         rcrc_r <= rcrc_nxt;
         gap_r <= gap_nxt;
         out_v_r <= out_v_nxt;
         out_d_r <= out_d_nxt;
         sk_v_r <= sk_v_nxt;
         sk_d_r <= sk_d_nxt;
      end
   end

   assign o_tx_valid = out_v_r;
   assign o_tx_data = out_d_r;
   assign o_probe_addr = cur_r;
   assign o_par_wr = pw_r;
   assign o_plc_run_pattern = pat_r;
   assign o_plc_retention_select = ret_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_b_r);

   AST_GAP_BEFORE_END: assert property (frame_end |-> $past(gap_r) >= 32'(GAP_CYC) - 32'h1) // see [RULE1]
      else $error("frame ended before idle gap");
   AST_DIAG_ECHO: assert property (frame_end && frame_ok && f_fn == FN_DIAG && rx_cnt_r == DIAG_LEN // see [RULE2]
                                   && f_start == 16'h0000 |=> st_r == ST_SEND && md_r == MD_COPY
                                   && tx_len_r == DIAG_LEN - 6'h02)
      else $error("diagnosis not echoed");
   AST_WORD_LIMIT: assert property (st_r == ST_CHECK |-> {11'h000, idx_r} < f_qty && f_qty <= MAX_WORDS) // see [RULE3]
      else $error("word index beyond quantity");
   AST_WRITE_ECHO: assert property (st_r == ST_COMMIT && !refuse && {11'h000, idx_r} == f_qty - 16'h0001 // see [RULE5]
                                    |=> st_r == ST_SEND && tx_len_r == WECHO_LEN && md_r == MD_COPY)
      else $error("write answer malformed");
   AST_NO_RESERVED: assert property (st_r == ST_COMMIT && cur_r[14:8] == FACTORY_RESERVED_GROUP // see [RULE7]
                                     |=> !pw_r.valid && st_r == ST_SEND)
      else $error("reserved group written");
   AST_LOCKED: assert property (st_r == ST_COMMIT && (i_lock_never || (i_lock_run && i_running)) // see [RULE8]
                                |=> !pw_r.valid && exc_r == EXC_REFUSED)
      else $error("locked parameter written");
   AST_RAM_ONLY: assert property (st_r == ST_COMMIT && !refuse // see [RULE9]
      |=> pw_r.valid && pw_r.ram_only == $past(cur_r[15]))
      else $error("ram only flag wrong");
   AST_ALIAS_READ: assert property (frame_end && frame_ok && f_fn == FN_READ && f_start[15] // see [RULE10]
      |=> md_r == MD_EXC)
      else $error("alias read answered with data");
   AST_RANGES: assert property (pat_r <= MAX_PLC_RUN_PATTERN // see [RULE11] see [RULE12]
      && ret_r <= MAX_PLC_RETENTION_SELECT)
      else $error("parameter out of range");
   AST_CHECK_ORDER: assert property (push && tx_idx_r == tx_len_r |=> tcrc_r == $past(tcrc_r) // see [RULE13]
      && (!push || push_d == $past(tcrc_r[15:8])))
      else $error("check byte order wrong");
   AST_SILENT_DROP: assert property (frame_end && !frame_ok |=> st_r == ST_IDLE) // see [RULE15] see [RULE14]
      else $error("bad frame answered");

   COV_DIAG: cover property (frame_end && frame_ok && f_fn == FN_DIAG ##1 st_r == ST_SEND);
   COV_WRITE: cover property (pw_r.valid && pw_r.ram_only);
   COV_REFUSE: cover property (st_r == ST_COMMIT && refuse);
   COV_STALL: cover property (sk_v_r && !i_tx_ready);
endmodule // rsw_slave

// [rsw_master_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Link master model: sends requests, takes answers
// ----------------------------------------
module rsw_master_model
   import rsw_pkg::*;
#(
   parameter int P_GAP_CYC = 35,
   parameter int P_CHAR_CYC = 10
) (
   input wire logic i_clk,            // System clock
   input wire logic i_stall,          // Slow taker of answer bytes
   input wire logic i_tx_valid,       // Answer byte valid
   input wire logic [7:0] i_tx_data,  // Answer byte
   output logic o_rx_valid,           // Request byte strobe
   output logic [7:0] o_rx_data,      // Request byte
   output logic o_tx_ready            // Answer byte taken
);
   logic [7:0] rsp_q[$];
   int cyc = 0;
   int last_req_cyc = 0;
   int first_rsp_cyc = 0;

   initial begin
      o_rx_valid = 1'b0;
      o_rx_data = 8'h5A;
      o_tx_ready = 1'b0;
   end

   // Answer capture; when stalled only one cycle in four takes a byte
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      o_tx_ready <= !i_stall || (cyc % 4 == 0);
      if (i_tx_valid && o_tx_ready) begin
         if (rsp_q.size() == 0) first_rsp_cyc <= cyc;
         rsp_q.push_back(i_tx_data);
      end
   end

   // Line idle first, then one byte per character time
   task automatic send_frame(input logic [7:0] f[$]);
      rsp_q = {};
      repeat (P_GAP_CYC + 2) @(posedge i_clk);
      foreach (f[i]) begin
         o_rx_valid <= 1'b1;
         o_rx_data <= f[i];
         @(posedge i_clk);
         o_rx_valid <= 1'b0;
         o_rx_data <= ~f[i]; // Stale byte is not left on the line
         last_req_cyc = cyc;
         repeat (P_CHAR_CYC - 1) @(posedge i_clk);
      end
   endtask

   // Collect until the answer has been quiet for a while
   task automatic wait_answer(input int quiet, output logic [7:0] r[$]);
      int idle = 0;
      int n = 0;
      int guard = 0;
      while (idle < quiet && guard < 3000) begin
         @(posedge i_clk);
         guard++;
         idle = (rsp_q.size() == n) ? idle + 1 : 0;
         n = rsp_q.size();
      end
      r = rsp_q;
   endtask
endmodule // rsw_master_model

// [rtu_slave_write_multi_and_address_map_tb_top.sv]
`timescale 1ns/1ps
module rtu_slave_write_multi_and_address_map_tb_top;
   import rsw_pkg::*;
   typedef logic [7:0] rsw_bytes_t[$];
   localparam int P_CHAR_NS = 200;
   localparam int GAP_CYC = (P_CHAR_NS * 7 + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic [7:0] i_station_addr = 8'h01;
   logic i_rx_valid, i_tx_ready, o_tx_valid, i_stall = 1'b0;
   logic [7:0] i_rx_data, o_tx_data;
   logic i_running = 1'b0, i_lock_run = 1'b0, i_lock_never = 1'b0;
   logic [15:0] o_probe_addr, o_plc_run_pattern, o_plc_retention_select;
   rsw_par_wr_t o_par_wr;
   rsw_par_wr_t wr_q[$];
   int n_errors = 0;
   int cmp_count = 0;
   int cycles = 0;

   always #(CLK_PERIOD_NS / 2) i_clk = ~i_clk;

   rsw_slave #(.P_CHAR_NS(P_CHAR_NS)) i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_station_addr(i_station_addr),
      .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .i_tx_ready(i_tx_ready), .o_tx_valid(o_tx_valid),
      .o_tx_data(o_tx_data), .i_running(i_running), .i_lock_run(i_lock_run), .i_lock_never(i_lock_never),
      .o_probe_addr(o_probe_addr), .o_par_wr(o_par_wr), .o_plc_run_pattern(o_plc_run_pattern),
      .o_plc_retention_select(o_plc_retention_select));

   rsw_master_model #(.P_GAP_CYC(GAP_CYC), .P_CHAR_CYC(P_CHAR_NS / CLK_PERIOD_NS)) i_model (.i_clk(i_clk),
      .i_stall(i_stall), .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .o_rx_valid(i_rx_valid),
      .o_rx_data(i_rx_data), .o_tx_ready(i_tx_ready));

   // ----------------------------------------
   // Strobe capture and hang guard
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (o_par_wr.valid === 1'b1) wr_q.push_back(o_par_wr);
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // Compare helpers
   // ----------------------------------------
   task automatic cmp_bytes(input string what, input rsw_bytes_t exp, input rsw_bytes_t got);
      logic bad;
      bad = (exp.size() != got.size());
      cmp_count++;
      foreach (exp[i]) if (i < got.size() && exp[i] !== got[i]) bad = 1'b1;
      if (bad) begin
         n_errors++;
         $display("unexpected %s expected %p seen %p", what, exp, got);
      end
   endtask

   task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (exp !== got) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_wr(input string what, input rsw_par_wr_t exp, input rsw_par_wr_t got);
      cmp_count++;
      if (exp !== got) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Frame check appended low byte first
   function automatic rsw_bytes_t framed(input rsw_bytes_t b);
      logic [15:0] c;
      c = CRC_INIT;
      foreach (b[i]) begin
         c ^= {8'h00, b[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      b.push_back(c[7:0]);
      b.push_back(c[15:8]);
      return b;
   endfunction

   task automatic xact(input rsw_bytes_t req, output rsw_bytes_t rsp);
      wr_q = {};
      i_model.send_frame(req);
      i_model.wait_answer(120, rsp);
   endtask

   // Write request, then echo or refusal plus the strobes it caused
   task automatic write_words(input logic [15:0] a, input logic [15:0] w[$], input logic [7:0] exc);
      rsw_bytes_t rsp;
      rsw_bytes_t req;
      logic [7:0] st;
      st = i_station_addr;
      req = '{st, FN_WMULTI, a[15:8], a[7:0], 8'h00, 8'(w.size()), 8'(2 * w.size())};
      foreach (w[i]) begin
         req.push_back(w[i][15:8]);
         req.push_back(w[i][7:0]);
      end
      xact(framed(req), rsp);
      if (exc == 8'h00) begin
         cmp_bytes("write echo", framed('{st, FN_WMULTI, a[15:8], a[7:0], 8'h00, 8'(w.size())}), rsp);
         foreach (w[i]) cmp_wr("write strobe", '{1'b1, a[15], {1'b0, a[14:0]} + 16'(i), w[i]},
            (wr_q.size() > 0) ? wr_q.pop_front() : rsw_par_wr_t'('x));
      end else cmp_bytes("write refusal", framed('{st, FN_WMULTI | FN_EXC_BIT, exc}), rsp);
      cmp16("stray strobes", 16'h0000, 16'(wr_q.size()));
   endtask

   task automatic read_words(input logic [15:0] a, input logic [15:0] w[$], input logic [7:0] exc);
      rsw_bytes_t rsp;
      rsw_bytes_t e;
      e = '{i_station_addr, FN_READ, 8'(2 * w.size())};
      foreach (w[i]) begin
         e.push_back(w[i][15:8]);
         e.push_back(w[i][7:0]);
      end
      if (exc != 8'h00) e = '{i_station_addr, FN_READ | FN_EXC_BIT, exc};
      xact(framed('{i_station_addr, FN_READ, a[15:8], a[7:0], 8'h00, 8'(w.size())}), rsp);
      cmp_bytes("read answer", framed(e), rsp);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      cmp16("run pattern", 16'h0000, o_plc_run_pattern);
      cmp16("retention", 16'h0000, o_plc_retention_select);
      read_words(REG_PLC_RUN_PATTERN, '{16'h0000, 16'h0000}, 8'h00);
   endtask

   task automatic t_diag();
      rsw_bytes_t req;
      rsw_bytes_t rsp;
      req = framed('{8'h01, FN_DIAG, 8'h00, 8'h00, 8'h12, 8'hAB});
      xact(req, rsp);
      cmp_bytes("diag echo", req, rsp);
      cmp16("diag check", 16'h14AD, {rsp[7], rsp[6]});
      cmp16("answer gap", 16'h0001, 16'(i_model.first_rsp_cyc - i_model.last_req_cyc >= GAP_CYC));
      xact(framed('{8'h01, 8'h41, 8'h00, 8'h00, 8'h00, 8'h00}), rsp);
      cmp_bytes("unknown function", framed('{8'h01, 8'hC1, EXC_FUNC}), rsp);
   endtask

   task automatic t_write();
      logic [15:0] w[$];
      i_station_addr <= 8'h02;
      i_stall <= 1'b1; // Slow master fills the answer buffer
      @(posedge i_clk); // New address settles before the frame is built
      write_words(16'h0004, '{16'h1388, 16'h0032}, 8'h00);
      i_stall <= 1'b0;
      for (int i = 0; i < 16; i++) w.push_back(16'h1000 + 16'(i));
      write_words(16'h0100, w, 8'h00);
      cmp16("probe address", 16'h010F, o_probe_addr);
      w.push_back(16'hBEEF);
      write_words(16'h0100, w, EXC_VALUE);
   endtask

   task automatic t_plc();
      write_words(REG_PLC_RUN_PATTERN, '{16'h0002, 16'h0001}, 8'h00);
      cmp16("run pattern", 16'h0002, o_plc_run_pattern);
      cmp16("retention", 16'h0001, o_plc_retention_select);
      write_words(16'h8A00, '{16'h0001}, 8'h00);
      cmp16("run pattern", 16'h0001, o_plc_run_pattern);
      write_words(REG_PLC_RUN_PATTERN, '{16'h0003}, EXC_REFUSED);
      write_words(REG_PLC_RETENTION_SELECT, '{16'h0002}, EXC_REFUSED);
      cmp16("run pattern", 16'h0001, o_plc_run_pattern);
      read_words(16'h8A00, '{16'h0000}, EXC_ADDR);
   endtask

   task automatic t_refuse();
      i_station_addr <= 8'h01;
      @(posedge i_clk);
      write_words(16'h6300, '{16'h0001}, EXC_REFUSED);
      read_words(16'h6300, '{16'h0000}, EXC_ADDR);
      i_lock_never <= 1'b1;
      write_words(16'h0004, '{16'h0001}, EXC_REFUSED);
      i_lock_never <= 1'b0;
      i_lock_run <= 1'b1;
      write_words(16'h0004, '{16'h0002}, 8'h00);
      i_running <= 1'b1;
      write_words(16'h0004, '{16'h0003}, EXC_REFUSED);
      i_running <= 1'b0;
      i_lock_run <= 1'b0;
   endtask

   task automatic t_silent();
      rsw_bytes_t req;
      rsw_bytes_t rsp;
      req = framed('{8'h03, FN_DIAG, 8'h00, 8'h00, 8'h55, 8'h66});
      xact(req, rsp);
      cmp16("answer length", 16'h0000, 16'(rsp.size()));
      req = framed('{8'h01, FN_WMULTI, 8'h00, 8'h04, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34});
      req[req.size() - 1] = ~req[req.size() - 1];
      xact(req, rsp);
      cmp16("answer length", 16'h0000, 16'(rsp.size() + wr_q.size()));
   endtask

   initial begin
      repeat (8) @(posedge i_clk);
      i_rst_b <= 1'b1;
      repeat (3) @(posedge i_clk);
      t_reset();
      t_diag();
      t_write();
      t_plc();
      t_refuse();
      t_silent();
      complete_run();
   end
endmodule // rtu_slave_write_multi_and_address_map_tb_top
